// ==== hdl/seewp_buf.sv ====
// Two-entry skid buffer with valid and ready on both sides.
module seewp_buf #(
  parameter int unsigned WIDTH = 18
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic out_valid_r, out_valid_nxt;
  logic [WIDTH-1:0] out_data_r, out_data_nxt;
  logic skid_valid_r, skid_valid_nxt;
  logic [WIDTH-1:0] skid_data_r, skid_data_nxt;
  logic in_ready_r, in_ready_nxt;

  // Ready is registered, so the second entry takes the word that was
  // already in flight when the drain side stalled.
  always_comb begin
    out_valid_nxt = out_valid_r;
    out_data_nxt = out_data_r;
    skid_valid_nxt = skid_valid_r;
    skid_data_nxt = skid_data_r;
    if (out_valid_r && out_ready) begin
      out_valid_nxt = 1'b0;
    end
    if (!out_valid_nxt && skid_valid_nxt) begin
      out_valid_nxt = 1'b1;
      out_data_nxt = skid_data_nxt;
      skid_valid_nxt = 1'b0;
    end
    if (in_valid && in_ready_r) begin
      if (!out_valid_nxt) begin
        out_valid_nxt = 1'b1;
        out_data_nxt = in_data;
      end else begin
        skid_valid_nxt = 1'b1;
        skid_data_nxt = in_data;
      end
    end
    in_ready_nxt = !skid_valid_nxt;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid_r <= 1'b0;
      skid_valid_r <= 1'b0;
      in_ready_r <= 1'b1;
    end else begin
      out_valid_r <= out_valid_nxt;
      skid_valid_r <= skid_valid_nxt;
      in_ready_r <= in_ready_nxt;
    end
    out_data_r <= out_data_nxt;
    skid_data_r <= skid_data_nxt;
  end

  assign in_ready = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data = out_data_r;

endmodule

// ==== hdl/seewp_pkg.sv ====
// Constants and types shared by the serial EEPROM write path.
package seewp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned WRITE_CYCLE_NS = 1000000;
  // A longest time, so the cycle count rounds down.
  localparam int unsigned WRITE_CYCLE_CYC = WRITE_CYCLE_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned PAGE_BYTES = 16;
  localparam logic [3:0] TYPE_ARRAY = 4'ha;
  localparam logic [3:0] TYPE_CONFIG = 4'hb;
  localparam logic [1:0] CONFIG_SELECT = 2'h3;
  localparam logic [4:0] ONE_BYTE = 5'h01;
  localparam logic [4:0] COUNT_MAX = 5'h1f;

  // ----------------------------------------------------------------
  // Protection configuration register layout
  // ----------------------------------------------------------------
  localparam int unsigned CFG_LOCK_BIT = 0;
  localparam int unsigned CFG_BLK_LSB = 1;
  localparam int unsigned CFG_EN_BIT = 3;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [3:0] CFG_UNLOCK_NIB = 4'h4;
  localparam logic [3:0] CFG_LOCK_NIB = 4'h6;
  localparam logic [7:0] IDLE_READ_BYTE = 8'hff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK,
    ST_PROG
  } seewp_state_type;

  typedef enum logic [1:0] {
    KIND_DEV,
    KIND_WORD,
    KIND_DATA
  } seewp_kind_type;

endpackage

// ==== hdl/seewp_top.sv ====
// Two-wire serial EEPROM client: write path, write cycle and protection.
module seewp_top
  import seewp_pkg::*;
#(
  parameter bit IS_8K = 1'b0,
  // Client address strap; the value is arbitrary.
  parameter logic [1:0] HW_ADDR = 2'h0,
  parameter int unsigned TWR_CYCLES = WRITE_CYCLE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Hardware protect pin
  input wire logic protect_pin,
  // Array programming port
  output logic array_wr_valid,
  input wire logic array_wr_ready,
  output logic [ADDR_W-1:0] array_wr_addr,
  output logic [7:0] array_wr_data,
  // Status
  output logic write_busy,
  output logic [7:0] protection_config_register,
  output logic soft_protect_enable,
  output logic [1:0] protected_block_select
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic scl_m_r, scl_s_r, scl_p_r;
  logic sda_m_r, sda_s_r, sda_p_r;
  logic prot_m_r, prot_s_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_p_r <= 1'b1;
      prot_m_r <= 1'b0;
      prot_s_r <= 1'b0;
    end else begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      scl_p_r <= scl_s_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_p_r <= sda_s_r;
      prot_m_r <= protect_pin;
      prot_s_r <= prot_m_r;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;

  assign scl_rise = scl_s_r && !scl_p_r;
  assign scl_fall = !scl_s_r && scl_p_r;
  assign start_det = scl_s_r && scl_p_r && sda_p_r && !sda_s_r;
  assign stop_det = scl_s_r && scl_p_r && !sda_p_r && sda_s_r;

  // ----------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------
  seewp_state_type state_r, state_nxt;
  seewp_kind_type kind_r, kind_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic sda_oe_r, sda_oe_nxt;
  logic sda_out_r;
  logic is_read_r, is_read_nxt;
  logic is_cfg_r, is_cfg_nxt;
  logic cfg_sel_r, cfg_sel_nxt;
  logic have_data_r, have_data_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [4:0] byte_cnt_r, byte_cnt_nxt;
  logic [7:0] cfg_data_r, cfg_data_nxt;
  logic [7:0] page_r [PAGE_BYTES];
  logic [7:0] page_nxt [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_vld_r, page_vld_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  logic [31:0] timer_r, timer_nxt;
  logic [4:0] idx_r, idx_nxt;
  logic busy_r;

  logic buf_in_valid, buf_in_ready;
  logic [1:0] row_top;
  logic soft_hit, dev_match, cfg_pattern_ok;
  logic [7:0] tx_byte;

  // Configured protection against the two highest bits of the row.
  // Block coverage decode
  always_comb begin
    row_top = IS_8K ? addr_r[9:8] : addr_r[8:7];
    soft_hit = 1'b0;
    if (cfg_r[CFG_EN_BIT]) begin
      case (cfg_r[CFG_BLK_LSB +: 2])
        2'b00: soft_hit = (row_top == 2'b11);
        2'b01: soft_hit = row_top[1];
        2'b10: soft_hit = (row_top != 2'b00);
        default: soft_hit = 1'b1;
      endcase
    end
  end

  assign dev_match = ((shift_r[7:4] == TYPE_ARRAY) || (shift_r[7:4] == TYPE_CONFIG)) &&
                     (IS_8K ? (shift_r[3] == HW_ADDR[1]) : (shift_r[3:2] == HW_ADDR));
  // A lock request must carry the matching guard nibble.
  assign cfg_pattern_ok = cfg_data_r[7:4] ==
                          (cfg_data_r[CFG_LOCK_BIT] ? CFG_LOCK_NIB : CFG_UNLOCK_NIB);
  assign tx_byte = (is_cfg_r && cfg_sel_r) ? cfg_r : IDLE_READ_BYTE;

  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    sda_oe_nxt = sda_oe_r;
    is_read_nxt = is_read_r;
    is_cfg_nxt = is_cfg_r;
    cfg_sel_nxt = cfg_sel_r;
    have_data_nxt = have_data_r;
    addr_nxt = addr_r;
    byte_cnt_nxt = byte_cnt_r;
    cfg_data_nxt = cfg_data_r;
    page_nxt = page_r;
    page_vld_nxt = page_vld_r;
    cfg_nxt = cfg_r;
    timer_nxt = timer_r;
    idx_nxt = idx_r;
    buf_in_valid = 1'b0;
    if (state_r == ST_PROG) begin
      sda_oe_nxt = 1'b0;
      if (timer_r != 32'h0) begin
        timer_nxt = timer_r - 32'h1;
      end
      if (!idx_r[4]) begin
        buf_in_valid = page_vld_r[idx_r[3:0]];
        if (!page_vld_r[idx_r[3:0]] || buf_in_ready) begin
          idx_nxt = idx_r + 5'h01;
        end
      end
      // Ready again once time is up and all bytes are handed over
      if (timer_r == 32'h0 && idx_r[4] && !array_wr_valid && buf_in_ready) begin
        state_nxt = ST_IDLE;
      end
    end else if (start_det) begin
      state_nxt = ST_RX;
      kind_nxt = KIND_DEV;
      bit_cnt_nxt = 4'h0;
      sda_oe_nxt = 1'b0;
      have_data_nxt = 1'b0;
    end else if (stop_det) begin
      state_nxt = ST_IDLE;
      sda_oe_nxt = 1'b0;
      have_data_nxt = 1'b0;
      // Stop after data starts the timed cycle
      if (have_data_r && !is_read_r) begin
        if (is_cfg_r) begin
          // Single-byte, unlocked, well-guarded register writes only
          if (cfg_sel_r && byte_cnt_r == ONE_BYTE && !cfg_r[CFG_LOCK_BIT] &&
              cfg_pattern_ok) begin
            cfg_nxt = {4'h0, cfg_data_r[3:0]};
            state_nxt = ST_PROG;
            timer_nxt = TWR_CYCLES;
            idx_nxt = 5'h10;
          end
        // Pin high protects the whole array
        end else if (!prot_s_r && !soft_hit) begin
          state_nxt = ST_PROG;
          timer_nxt = TWR_CYCLES;
          idx_nxt = 5'h00;
        end
      end
    end else begin
      case (state_r)
        ST_RX: begin
          if (scl_rise && bit_cnt_r != 4'h8) begin
            shift_nxt = {shift_r[6:0], sda_s_r};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            state_nxt = ST_ACK;
            sda_oe_nxt = 1'b1;
            case (kind_r)
              KIND_DEV: begin
                // A mismatched address gets no ack
                if (!dev_match) begin
                  state_nxt = ST_IDLE;
                  sda_oe_nxt = 1'b0;
                end
                is_read_nxt = shift_r[0];
                is_cfg_nxt = (shift_r[7:4] == TYPE_CONFIG);
                if (!shift_r[0]) begin
                  // High address bits from the device byte
                  addr_nxt[9] = IS_8K ? shift_r[2] : 1'b0;
                  addr_nxt[8] = shift_r[1];
                end
                kind_nxt = KIND_WORD;
              end
              KIND_WORD: begin
                addr_nxt[7:0] = shift_r;
                cfg_sel_nxt = is_cfg_r && (shift_r[7:6] == CONFIG_SELECT);
                byte_cnt_nxt = 5'h00;
                page_vld_nxt = '0;
                kind_nxt = KIND_DATA;
              end
              default: begin
                // Bytes land in the one-row page buffer
                page_nxt[addr_r[3:0]] = shift_r;
                page_vld_nxt[addr_r[3:0]] = 1'b1;
                // Carry is dropped, so the page wraps
                addr_nxt[3:0] = addr_r[3:0] + 4'h1;
                if (byte_cnt_r == 5'h00) begin
                  cfg_data_nxt = shift_r;
                end
                if (byte_cnt_r != COUNT_MAX) begin
                  byte_cnt_nxt = byte_cnt_r + 5'h01;
                end
                have_data_nxt = 1'b1;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_nxt = 4'h0;
            if (is_read_r && kind_r == KIND_WORD) begin
              state_nxt = ST_TX;
              shift_nxt = tx_byte;
              sda_oe_nxt = !tx_byte[7];
            end else begin
              state_nxt = ST_RX;
              sda_oe_nxt = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == 4'h7) begin
              state_nxt = ST_TXACK;
              sda_oe_nxt = 1'b0;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b1};
              sda_oe_nxt = !shift_r[6];
              bit_cnt_nxt = bit_cnt_r + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          // The host's answer is kept in bit 0 until the falling edge.
          if (scl_rise) begin
            shift_nxt[0] = sda_s_r;
          end else if (scl_fall) begin
            bit_cnt_nxt = 4'h0;
            if (!shift_r[0]) begin
              state_nxt = ST_TX;
              shift_nxt = tx_byte;
              sda_oe_nxt = !tx_byte[7];
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      kind_r <= KIND_DEV;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      sda_oe_r <= 1'b0;
      sda_out_r <= 1'b0;
      is_read_r <= 1'b0;
      is_cfg_r <= 1'b0;
      cfg_sel_r <= 1'b0;
      have_data_r <= 1'b0;
      addr_r <= '0;
      byte_cnt_r <= 5'h00;
      cfg_data_r <= 8'h00;
      page_vld_r <= '0;
      cfg_r <= CFG_RESET;
      timer_r <= 32'h0;
      idx_r <= 5'h10;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      sda_oe_r <= sda_oe_nxt;
      sda_out_r <= 1'b0;
      is_read_r <= is_read_nxt;
      is_cfg_r <= is_cfg_nxt;
      cfg_sel_r <= cfg_sel_nxt;
      have_data_r <= have_data_nxt;
      addr_r <= addr_nxt;
      byte_cnt_r <= byte_cnt_nxt;
      cfg_data_r <= cfg_data_nxt;
      page_vld_r <= page_vld_nxt;
      cfg_r <= cfg_nxt;
      timer_r <= timer_nxt;
      idx_r <= idx_nxt;
      busy_r <= (state_nxt == ST_PROG);
    end
    page_r <= page_nxt;
  end

  // ----------------------------------------------------------------
  // Programming buffer
  // ----------------------------------------------------------------
  // A stall on the array port holds the write cycle open rather than
  // dropping bytes, so the cycle can outlast the nominal time.
  seewp_buf #(
    .WIDTH(ADDR_W + 8)
  ) u_buf (
    .clk(clk),
    .rst(rst),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data({addr_r[9:4], idx_r[3:0], page_r[idx_r[3:0]]}),
    .out_valid(array_wr_valid),
    .out_ready(array_wr_ready),
    .out_data({array_wr_addr, array_wr_data})
  );

  assign sda_out = sda_out_r;
  assign sda_oe = sda_oe_r;
  assign write_busy = busy_r;
  assign protection_config_register = cfg_r;
  assign soft_protect_enable = cfg_r[CFG_EN_BIT];
  assign protected_block_select = cfg_r[CFG_BLK_LSB +: 2];

endmodule

// ==== tb/seewp_chk.sv ====
// Port checker for the serial EEPROM write path.
module seewp_chk
  import seewp_pkg::*;
#(
  parameter bit IS_8K = 1'b0,
  parameter logic [1:0] HW_ADDR = 2'h0,
  parameter int unsigned TWR_CYCLES = 50
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus and pin
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic protect_pin,
  // Array port
  input wire logic array_wr_valid,
  input wire logic array_wr_ready,
  input wire logic [ADDR_W-1:0] array_wr_addr,
  input wire logic [7:0] array_wr_data,
  // Status
  input wire logic write_busy,
  input wire logic [7:0] protection_config_register,
  input wire logic soft_protect_enable,
  input wire logic [1:0] protected_block_select
);
  logic [19:0] cnt_r, cnt_nxt;
  logic seen_r, seen_nxt;
  logic [ADDR_W-1:0] last_r, last_nxt;
  logic take;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Busy length and the last word taken within one cycle.
  assign take = array_wr_valid & array_wr_ready;
  always_comb begin
    cnt_nxt = (write_busy & !rst) ? cnt_r + 20'h00001 : 20'h00000;
    seen_nxt = write_busy & !rst & (seen_r | take);
    last_nxt = take ? array_wr_addr : last_r;
  end
  always_ff @(posedge clk) begin
    cnt_r <= cnt_nxt;
    seen_r <= seen_nxt;
    last_r <= last_nxt;
  end

  sequence s_stalled;
    array_wr_valid && !array_wr_ready;
  endsequence
  sequence s_held;
    array_wr_valid && $stable(array_wr_addr) && $stable(array_wr_data);
  endsequence

  property p_word_held; s_stalled |=> s_held; endproperty
  a_word_held: assert property (p_word_held)
    else $error("offered word changed while stalled");
  property p_quiet; write_busy |-> !sda_oe; endproperty
  a_quiet: assert property (p_quiet)
    else $error("bus driven during programming");
  property p_word_busy; array_wr_valid |-> write_busy; endproperty
  a_word_busy: assert property (p_word_busy)
    else $error("word offered outside programming");
  property p_width; array_wr_valid |-> (IS_8K || !array_wr_addr[9]); endproperty
  a_width: assert property (p_width)
    else $error("address beyond array width");
  property p_row; array_wr_valid && seen_r |-> array_wr_addr[9:4] == last_r[9:4]; endproperty
  a_row: assert property (p_row)
    else $error("page write left its row");
  property p_index; array_wr_valid && seen_r |-> array_wr_addr[3:0] > last_r[3:0]; endproperty
  a_index: assert property (p_index)
    else $error("page index not ascending");
  property p_length; $fell(write_busy) |-> cnt_r >= TWR_CYCLES - 1; endproperty
  a_length: assert property (p_length)
    else $error("programming cycle too short");
  property p_fields;
    soft_protect_enable == protection_config_register[3] &&
      protected_block_select == protection_config_register[2:1] &&
      protection_config_register[7:4] == 4'h0;
  endproperty
  a_fields: assert property (p_fields)
    else $error("protection fields disagree");
  property p_commit; $changed(protection_config_register) |-> ##[0:1] write_busy; endproperty
  a_commit: assert property (p_commit)
    else $error("config changed without a write cycle");
endmodule

bind seewp_top seewp_chk #(.IS_8K(IS_8K), .HW_ADDR(HW_ADDR), .TWR_CYCLES(TWR_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .protect_pin(protect_pin), .array_wr_valid(array_wr_valid),
  .array_wr_ready(array_wr_ready), .array_wr_addr(array_wr_addr),
  .array_wr_data(array_wr_data), .write_busy(write_busy),
  .protection_config_register(protection_config_register),
  .soft_protect_enable(soft_protect_enable), .protected_block_select(protected_block_select)
);

// ==== tb/seewp_host.sv ====
// Two-wire bus host model issuing write and polling sequences.
module seewp_host #(
  parameter int HALF = 10
) (
  // Clock
  input wire logic clk,
  // Bus
  input wire logic sda,
  output logic scl,
  output logic host_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl = 1'b1;
    host_oe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // SDA moves two cycles after SCL falls, so no false Start or Stop is seen.
  task automatic put_bit(input logic b);
    tick(2);
    host_oe = !b;
    tick(HALF - 2);
    scl = 1'b1;
    tick(HALF);
    scl = 1'b0;
  endtask
  task automatic start();
    tick(2);
    host_oe = 1'b0;
    tick(HALF - 2);
    scl = 1'b1;
    tick(HALF);
    host_oe = 1'b1;
    tick(HALF);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(2);
    host_oe = 1'b1;
    tick(HALF - 2);
    scl = 1'b1;
    tick(HALF);
    host_oe = 1'b0;
    tick(HALF);
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    tick(2);
    host_oe = 1'b0;
    tick(HALF - 2);
    scl = 1'b1;
    tick(HALF / 2);
    ack = !sda;
    tick(HALF / 2);
    scl = 1'b0;
  endtask
  task automatic rd_byte(input logic nack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      tick(2);
      host_oe = 1'b0;
      tick(HALF - 2);
      scl = 1'b1;
      tick(HALF / 2);
      b[i] = sda;
      tick(HALF / 2);
      scl = 1'b0;
    end
    put_bit(nack);
  endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the serial EEPROM write path.
module testbench
  import seewp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned TWR = 600;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic protect_pin = 1'b0;
  logic rdy = 1'b0;
  logic scl, host_oe, sda, sda_out, sda_oe, v, busy, spe;
  logic [9:0] addr;
  logic [7:0] data, cfg;
  logic [1:0] pbs;
  logic [15:0] rnd = 16'h0010;
  logic [15:0] dsd = 16'h0010;
  logic [17:0] q [$];
  int stall = 0;
  int n_fail = 0;
  int cmp_count = 0;

  always #4 clk = ~clk;
  // Open-drain wire with pull-up.
  assign sda = !(sda_oe | host_oe);

  seewp_host host (.clk(clk), .sda(sda), .scl(scl), .host_oe(host_oe));
  seewp_top #(.IS_8K(1'b0), .HW_ADDR(2'h0), .TWR_CYCLES(TWR)) DUT (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .protect_pin(protect_pin), .array_wr_valid(v), .array_wr_ready(rdy),
    .array_wr_addr(addr), .array_wr_data(data), .write_busy(busy),
    .protection_config_register(cfg), .soft_protect_enable(spe), .protected_block_select(pbs)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic poll(input logic ready_now);
    logic ack;
    ack = 1'b0;
    for (int i = 0; i < 40 && ack !== 1'b1; i++) begin
      host.start();
      host.wr_byte({TYPE_ARRAY, 4'h0}, ack);
      host.stop();
      if (i == 0) chk(ack, ready_now);
    end
    chk({ack, busy, sda_out}, 3'b100);
    if (ack !== 1'b1) summarize();
  endtask
  // A stalled array side makes the two-entry buffer fill and refuse.
  task automatic wr(input logic [9:0] a, input int n, input logic prog, input logic flip);
    logic ack;
    logic [3:0] ix;
    logic [7:0] d [16];
    logic [15:0] hit;
    hit = 16'h0000;
    host.start();
    host.wr_byte({TYPE_ARRAY, 2'h0, a[8], 1'b0}, ack);
    chk(ack, 1'b1);
    host.wr_byte(a[7:0], ack);
    chk(ack, 1'b1);
    // At most 16 bytes, so a wrap never overwrites a sent byte.
    for (int i = 0; i < n; i++) begin
      dsd = lfsr(dsd);
      ix = a[3:0] + 4'(i);
      d[ix] = dsd[7:0];
      hit[ix] = 1'b1;
      host.wr_byte(dsd[7:0], ack);
      chk(ack, 1'b1);
    end
    for (int i = 0; i < 16; i++) begin
      if (prog && hit[i]) q.push_back({a[9:4], 4'(i), d[i]});
    end
    host.stop();
    protect_pin = protect_pin ^ flip;
    repeat (3) @(negedge clk);
    chk(busy, prog);
    poll(!prog);
  endtask
  task automatic cfg_wr(input logic [7:0] val, input int n, input logic commit);
    logic ack;
    host.start();
    host.wr_byte({TYPE_CONFIG, 4'h0}, ack);
    chk(ack, 1'b1);
    host.wr_byte(8'hc0, ack);
    chk(ack, 1'b1);
    repeat (n) begin
      host.wr_byte(val, ack);
      chk(ack, 1'b1);
    end
    host.stop();
    repeat (3) @(negedge clk);
    chk(busy, commit);
    poll(!commit);
  endtask
  // Random read of the register: word byte, repeated Start, read byte.
  task automatic cfg_rd(output logic [7:0] val);
    logic ack;
    host.start();
    host.wr_byte({TYPE_CONFIG, 4'h0}, ack);
    host.wr_byte(8'hc0, ack);
    host.start();
    host.wr_byte({TYPE_CONFIG, 4'h1}, ack);
    chk(ack, 1'b1);
    host.rd_byte(1'b1, val);
    host.stop();
  endtask

  always @(negedge clk) begin
    rnd <= lfsr(rnd);
    rdy <= (rnd[0] | rnd[2]) & (stall == 0);
    if (stall != 0 && v) stall <= stall - 1;
  end
  always @(posedge clk) begin
    if (!rst && v && rdy) begin
      if (q.size() == 0) begin
        n_fail++;
        $display("BAD %0t unexpected word at %h", $time, addr);
      end else begin
        chk({addr, data}, q.pop_front());
      end
    end
  end

  initial begin
    logic ack;
    logic [7:0] bad [2];
    logic [9:0] bnd [4];
    logic [7:0] rb;
    bad = '{8'ha4, 8'h80};
    bnd = '{10'h180, 10'h100, 10'h080, 10'h000};
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    wr(10'h1a5, 1, 1'b1, 1'b0);
    stall = 200;
    wr(10'h0f5, 16, 1'b1, 1'b0);
    wr(10'h033, 3, 1'b1, 1'b1);
    wr(10'h044, 2, 1'b0, 1'b1);
    foreach (bad[k]) begin
      host.start();
      host.wr_byte(bad[k], ack);
      chk(ack, 1'b0);
      host.stop();
    end
    for (int b = 0; b < 4; b++) begin
      cfg_wr({4'h4, 1'b1, 2'(b), 1'b0}, 1, 1'b1);
      chk({spe, pbs, cfg}, {1'b1, 2'(b), 4'h0, 1'b1, 2'(b), 1'b0});
      cfg_rd(rb);
      chk(rb, {4'h0, 1'b1, 2'(b), 1'b0});
      wr(bnd[b], 1, 1'b0, 1'b0);
      if (b < 3) wr(bnd[b] - 10'h001, 1, 1'b1, 1'b0);
    end
    cfg_wr(8'h40, 2, 1'b0);
    chk(cfg, 8'h0e);
    cfg_wr(8'h61, 1, 1'b1);
    cfg_wr(8'h4e, 1, 1'b0);
    chk(cfg, 8'h01);
    wr(10'h1ff, 1, 1'b1, 1'b0);
    for (int i = 0; i < 1000 && q.size() != 0; i++) @(negedge clk);
    chk(18'(q.size()), 18'h00000);
    summarize();
  end
endmodule
